/* pkg/card_reader_pkg.sv */
// Shared constants and types for the card reader readiness block.
package card_reader_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int POWER_DELAY_MS = 3000;
    localparam int POWER_DELAY_CYCLES = POWER_DELAY_MS * 1000 * CLK_MHZ;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Positions of the synchronised operator and mechanism inputs
    // ------------------------------------------------------------
    localparam int IN_W = 14;
    localparam int IX_POWER_ON = 0;
    localparam int IX_POWER_OFF = 1;
    localparam int IX_SYS_POWER = 2;
    localparam int IX_START = 3;
    localparam int IX_STOP = 4;
    localparam int IX_FAULT_RESET = 5;
    localparam int IX_END_OF_DECK = 6;
    localparam int IX_VALIDITY_ON = 7;
    localparam int IX_LOCAL_RUN = 8;
    localparam int IX_COVER_CLOSED = 9;
    localparam int IX_HOPPER_EMPTY = 10;
    localparam int IX_STACKER_FULL = 11;
    localparam int IX_SENSE_FAULT = 12;
    localparam int IX_FEED_FAULT = 13;

    // ------------------------------------------------------------
    // Character path
    // ------------------------------------------------------------
    localparam int CHAR_W = 6;
    localparam logic [5:0] NULL_CHAR = 6'h00;

    typedef enum logic {CYCLE_IDLE, CYCLE_RUN} cycle_state_t;

endpackage : card_reader_pkg

/* pkg/sync_if.sv */
// Carrier between the readiness logic and its input synchroniser.
`timescale 1ns/1ps
interface sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport client (output raw, input synced);
    modport syncer (input raw, output synced);
endinterface : sync_if

/* hw/input_sync.sv */
// Two-stage synchroniser bank for level inputs.
`timescale 1ns/1ps
module input_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Inputs and synchronised copies
    sync_if.syncer port
);

    logic [W-1:0] stage1_r;
    logic [W-1:0] stage2_r;

    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= port.raw;
            stage2_r <= stage1_r;
        end
    end

    assign port.synced = stage2_r;

endmodule : input_sync

/* hw/card_reader_ready_status.sv */
// Readiness, fault and flag logic of a punched card reader.
// Operation
// (RULE_01) Unavailable while unstarted, hopper empty, stacker full or fault latched.
// (RULE_02) While unavailable, program requests including card cycle starts are ignored; data retrieval still clears flag and buffer.
// (RULE_03) Status bit reads unavailable on any cause and when power is off.
// (RULE_04) Sense faults are monitored always except during a card cycle; they are also ignored while control is not active.
// (RULE_05) Sense fault latches, makes unavailable, sets error status and lamp.
// (RULE_06) Jam or pick failure latches jam fault, unavailable, motors stop.
// (RULE_07) Jam fault raises the flag and a readable jam status bit.
// (RULE_08) Bad punch latches only with checking on, alphanumeric; sets error.
// (RULE_09) After power-on control waits a fixed delay; motors start at once.
// (RULE_10) Start clears unavailable only if no other cause is present.
// (RULE_11) Stop makes unavailable at once; current card still reaches stacker.
// (RULE_12) Fault reset clears sense, jam and bad punch indicators together.
// (RULE_13) End-of-deck press with empty hopper sets indicator and flag.
// (RULE_14) Invalid alphanumeric punch is delivered as an all-zero character.
// (RULE_15) With checking on an invalid punch also latches fault and stops.
// (RULE_16) Local mode feeds continuously until empty, then latches jam fault.
// (RULE_17) Remote card cycles start only while unavailable is clear.
// (RULE_18) Data retrieval clears flag and buffer; next column overwrites it.
// (RULE_19) Inputs are synchronised; reset clears faults and makes unavailable. Card transport, column and processor request inputs bypass the synchroniser.
`timescale 1ns/1ps
module card_reader_ready_status #(
    parameter int unsigned POWER_DELAY = card_reader_pkg::POWER_DELAY_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Operator buttons and switches
    input wire logic powerOnButton,
    input wire logic powerOffButton,
    input wire logic systemPowerOn,
    input wire logic startButton,
    input wire logic stopButton,
    input wire logic faultResetButton,
    input wire logic end_of_deck_button,
    input wire logic validityEnable,
    input wire logic localRun,
    // Interlocks and mechanism checks
    input wire logic coverClosed,
    input wire logic hopperEmpty,
    input wire logic stackerFull,
    input wire logic senseFault,
    input wire logic feedFault,
    // Card transport and column data
    input wire logic cardAtStacker,
    input wire logic columnStrobe,
    input wire logic columnInvalid,
    input wire logic binaryMode,
    input wire logic [5:0] columnChar,
    // Processor requests
    input wire logic cycleRequest,
    input wire logic dataRetrieve,
    // Status and indicators
    output logic notReady,
    output logic notReadyStatus,
    output logic errorStatus,
    output logic errorLamp,
    output logic senseFaultLamp,
    output logic cardJamLamp,
    output logic badPunchLamp,
    output logic jamStatus,
    output logic endOfDeckStatus,
    output logic flag,
    // Power and motion
    output logic powerLamp,
    output logic motorOn,
    output logic controlActive,
    output logic cardCycle,
    // Character buffer
    output logic [5:0] charData,
    output logic charValid
);

    localparam int DW = $clog2(POWER_DELAY + 1);
    localparam logic [DW-1:0] DELAY_LAST = DW'(POWER_DELAY - 1);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (POWER_DELAY < 1 || POWER_DELAY > 32'h7FFFFFFF) begin : g_chk
        $error("POWER_DELAY out of range");
    end

    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction : rise

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    sync_if #(.W(card_reader_pkg::IN_W)) syn ();
    logic [card_reader_pkg::IN_W-1:0] in_s;
    logic [card_reader_pkg::IN_W-1:0] inPrev_r;

    assign syn.raw = {feedFault, senseFault, stackerFull, hopperEmpty,
                      coverClosed, localRun, validityEnable,
                      end_of_deck_button, faultResetButton, stopButton,
                      startButton, systemPowerOn, powerOffButton,
                      powerOnButton};
    // (RULE_19) Two-stage synchroniser.
    input_sync #(.W(card_reader_pkg::IN_W)) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .port(syn.syncer)
    );
    assign in_s = syn.synced;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            inPrev_r <= '0;
        end else begin
            inPrev_r <= in_s;
        end
    end

    logic pressPowerOn;
    logic pressPowerOff;
    logic pressStart;
    logic pressStop;
    logic pressReset;
    logic pressEod;
    logic hopEmpty;
    logic stackFull;
    logic valOn;
    logic local_s;
    assign pressPowerOn = rise(in_s[card_reader_pkg::IX_POWER_ON],
                               inPrev_r[card_reader_pkg::IX_POWER_ON])
                        | rise(in_s[card_reader_pkg::IX_SYS_POWER],
                               inPrev_r[card_reader_pkg::IX_SYS_POWER]);
    assign pressPowerOff = rise(in_s[card_reader_pkg::IX_POWER_OFF],
                                inPrev_r[card_reader_pkg::IX_POWER_OFF]);
    assign pressStart = rise(in_s[card_reader_pkg::IX_START],
                             inPrev_r[card_reader_pkg::IX_START]);
    assign pressStop = rise(in_s[card_reader_pkg::IX_STOP],
                            inPrev_r[card_reader_pkg::IX_STOP]);
    assign pressReset = rise(in_s[card_reader_pkg::IX_FAULT_RESET],
                             inPrev_r[card_reader_pkg::IX_FAULT_RESET]);
    assign pressEod = rise(in_s[card_reader_pkg::IX_END_OF_DECK],
                           inPrev_r[card_reader_pkg::IX_END_OF_DECK]);
    assign hopEmpty = in_s[card_reader_pkg::IX_HOPPER_EMPTY];
    assign stackFull = in_s[card_reader_pkg::IX_STACKER_FULL];
    assign valOn = in_s[card_reader_pkg::IX_VALIDITY_ON];
    assign local_s = in_s[card_reader_pkg::IX_LOCAL_RUN];

    // ------------------------------------------------------------
    // Power and control-logic delay
    // ------------------------------------------------------------
    logic powerOn_r;
    logic active_r;
    logic [DW-1:0] delayCount_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            powerOn_r <= 1'b0;
        end else if (!in_s[card_reader_pkg::IX_COVER_CLOSED]
                     || pressPowerOff) begin
            powerOn_r <= 1'b0;
        end else if (pressPowerOn) begin
            powerOn_r <= 1'b1;
        end
    end

    // (RULE_09) Delay before control.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            delayCount_r <= '0;
            active_r <= 1'b0;
        end else if (!powerOn_r) begin
            delayCount_r <= '0;
            active_r <= 1'b0;
        end else if (!active_r) begin
            if (delayCount_r == DELAY_LAST) begin
                active_r <= 1'b1;
            end else begin
                delayCount_r <= delayCount_r + DW'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------
    logic senseFault_r;
    logic cardJam_r;
    logic badPunch_r;
    logic started_r;
    logic localFeed_r;
    card_reader_pkg::cycle_state_t cycle_r;
    logic senseSet;
    logic jamSet;
    logic badSet;
    logic invalidAlpha;

    assign invalidAlpha = columnStrobe & columnInvalid & ~binaryMode
                        & (cycle_r == card_reader_pkg::CYCLE_RUN);
    // (RULE_04) No sense monitoring in a cycle.
    assign senseSet = in_s[card_reader_pkg::IX_SENSE_FAULT] & active_r
                    & (cycle_r == card_reader_pkg::CYCLE_IDLE);
    // (RULE_16) Local deck runs out.
    assign jamSet = (in_s[card_reader_pkg::IX_FEED_FAULT] & active_r)
                  | (localFeed_r & hopEmpty
                     & (cycle_r == card_reader_pkg::CYCLE_IDLE));
    // (RULE_15) Checked invalid punch.
    assign badSet = invalidAlpha & valOn;

    // (RULE_12) Fault reset, set wins.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            senseFault_r <= 1'b0;
        end else if (senseSet) begin
            senseFault_r <= 1'b1;
        end else if (pressReset) begin
            senseFault_r <= 1'b0;
        end
    end

    // (RULE_06) Jam latch.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cardJam_r <= 1'b0;
        end else if (jamSet) begin
            cardJam_r <= 1'b1;
        end else if (pressReset) begin
            cardJam_r <= 1'b0;
        end
    end

    // (RULE_08) Bad punch latch.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            badPunch_r <= 1'b0;
        end else if (badSet) begin
            badPunch_r <= 1'b1;
        end else if (pressReset) begin
            badPunch_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Readiness
    // ------------------------------------------------------------
    logic otherCause;
    assign otherCause = hopEmpty | stackFull | senseFault_r | cardJam_r
                      | badPunch_r | ~active_r;

    // (RULE_10) Start only with no other cause.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            started_r <= 1'b0;
        end else if (pressStop || !active_r) begin
            started_r <= 1'b0;
        end else if (pressStart && !otherCause) begin
            started_r <= 1'b1;
        end
    end

    // (RULE_01) Unavailable causes.
    assign notReady = ~started_r | otherCause;
    // (RULE_03) Power off reads unavailable.
    assign notReadyStatus = notReady | ~powerOn_r;

    // ------------------------------------------------------------
    // Card cycle
    // ------------------------------------------------------------
    logic beginCycle;
    // (RULE_02) Ignored while unavailable.
    // (RULE_17) Remote start gated.
    assign beginCycle = (cycle_r == card_reader_pkg::CYCLE_IDLE) & ~notReady
                      & (local_s | cycleRequest);

    // (RULE_11) Card runs out before halting.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cycle_r <= card_reader_pkg::CYCLE_IDLE;
        end else begin
            unique case (cycle_r)
                card_reader_pkg::CYCLE_IDLE: begin
                    if (beginCycle) begin
                        cycle_r <= card_reader_pkg::CYCLE_RUN;
                    end
                end
                card_reader_pkg::CYCLE_RUN: begin
                    if (cardAtStacker || cardJam_r || jamSet) begin
                        cycle_r <= card_reader_pkg::CYCLE_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            localFeed_r <= 1'b0;
        end else if (jamSet || !local_s || pressStop) begin
            localFeed_r <= 1'b0;
        end else if (beginCycle) begin
            localFeed_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // End of deck and flag
    // ------------------------------------------------------------
    logic eod_r;
    logic flag_r;
    logic eodSet;
    logic flagSet;
    assign eodSet = pressEod & hopEmpty;

    // (RULE_13) End-of-deck indicator.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            eod_r <= 1'b0;
        end else if (eodSet) begin
            eod_r <= 1'b1;
        end else if (!hopEmpty) begin
            eod_r <= 1'b0;
        end
    end

    // (RULE_07) Jam raises flag.
    assign flagSet = (jamSet & ~cardJam_r) | eodSet | columnStrobe
                   & (cycle_r == card_reader_pkg::CYCLE_RUN)
                   | ((cycle_r == card_reader_pkg::CYCLE_RUN)
                      & cardAtStacker);

    // (RULE_18) Retrieval clears, set wins.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_r <= 1'b0;
        end else if (flagSet) begin
            flag_r <= 1'b1;
        end else if (dataRetrieve) begin
            flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Character buffer
    // ------------------------------------------------------------
    logic [5:0] char_r;
    logic charValid_r;
    logic colTaken;
    assign colTaken = columnStrobe & (cycle_r == card_reader_pkg::CYCLE_RUN);

    // (RULE_14) Invalid punch becomes zero.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            char_r <= card_reader_pkg::NULL_CHAR;
            charValid_r <= 1'b0;
        end else if (colTaken) begin
            char_r <= invalidAlpha ? card_reader_pkg::NULL_CHAR : columnChar;
            charValid_r <= 1'b1;
        end else if (dataRetrieve) begin
            char_r <= card_reader_pkg::NULL_CHAR;
            charValid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // (RULE_05) Error status and lamp.
    assign errorStatus = senseFault_r | badPunch_r;
    assign errorLamp = senseFault_r | badPunch_r;
    assign senseFaultLamp = senseFault_r;
    assign cardJamLamp = cardJam_r;
    assign badPunchLamp = badPunch_r;
    assign jamStatus = cardJam_r;
    assign endOfDeckStatus = eod_r;
    assign flag = flag_r;
    assign powerLamp = powerOn_r;
    // (RULE_09) Motors run from power-on.
    assign motorOn = powerOn_r & ~cardJam_r;
    assign controlActive = active_r;
    assign cardCycle = (cycle_r == card_reader_pkg::CYCLE_RUN);
    assign charData = char_r;
    assign charValid = charValid_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_causes;
        @(posedge core_clk) disable iff (!reset_n)
        (hopEmpty || stackFull || cardJam_r || senseFault_r || badPunch_r)
            |-> notReady;
    endproperty
    a_causes: assert property (p_causes) // RULE_01
        else $error("unavailable not shown for a cause");

    property p_ignore;
        @(posedge core_clk) disable iff (!reset_n)
        (notReady && !cardCycle) |=> !cardCycle;
    endproperty
    a_ignore: assert property (p_ignore) // RULE_02
        else $error("cycle began while unavailable");

    property p_power_status;
        @(posedge core_clk) disable iff (!reset_n)
        !powerOn_r |-> notReadyStatus ##1 !controlActive;
    endproperty
    a_power_status: assert property (p_power_status) // RULE_03
        else $error("status ready while power off");

    property p_sense_gap;
        @(posedge core_clk) disable iff (!reset_n)
        (cardCycle && !senseFault_r) |=> !senseFault_r;
    endproperty
    a_sense_gap: assert property (p_sense_gap) // RULE_04
        else $error("sense fault latched during cycle");

    property p_sense_err;
        @(posedge core_clk) disable iff (!reset_n)
        senseSet |=> senseFault_r && errorStatus && errorLamp && notReady;
    endproperty
    a_sense_err: assert property (p_sense_err) // RULE_05
        else $error("sense fault effects missing");

    property p_jam;
        @(posedge core_clk) disable iff (!reset_n)
        jamSet |=> cardJam_r && !motorOn && flag && jamStatus;
    endproperty
    a_jam: assert property (p_jam) // RULE_07
        else $error("jam effects missing");

    property p_bad_gate;
        @(posedge core_clk) disable iff (!reset_n)
        (!valOn && !badPunch_r) |=> !badPunch_r;
    endproperty
    a_bad_gate: assert property (p_bad_gate) // RULE_08
        else $error("bad punch latched with checking off");

    property p_delay;
        @(posedge core_clk) disable iff (!reset_n)
        $rose(active_r) |-> powerOn_r && delayCount_r == DELAY_LAST;
    endproperty
    a_delay: assert property (p_delay) // RULE_09
        else $error("control active before delay end");

    property p_reset_clear;
        @(posedge core_clk) disable iff (!reset_n)
        (pressReset && !senseSet && !jamSet && !badSet)
            |=> !senseFault_r && !cardJam_r && !badPunch_r;
    endproperty
    a_reset_clear: assert property (p_reset_clear) // RULE_12
        else $error("fault reset left an indicator");

    property p_zero_char;
        @(posedge core_clk) disable iff (!reset_n)
        invalidAlpha |=> charValid && charData == card_reader_pkg::NULL_CHAR;
    endproperty
    a_zero_char: assert property (p_zero_char) // RULE_14
        else $error("invalid punch not delivered as zero");

endmodule : card_reader_ready_status

/* bench/proc_ctrl_model.sv */
// Processor side model that issues card cycle and retrieve requests.
`timescale 1ns/1ps
module proc_ctrl_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bench commands
    input wire logic askCycle,
    input wire logic take,
    // Requests to the reader
    output logic cycleRequest,
    output logic dataRetrieve
);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cycleRequest <= 1'h0;
        end else begin
            cycleRequest <= askCycle;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dataRetrieve <= 1'h0;
        end else begin
            dataRetrieve <= take;
        end
    end
endmodule : proc_ctrl_model

/* bench/card_reader_ready_status_tb.sv */
// Self-checking bench for the card reader readiness block.
`timescale 1ns/1ps
module card_reader_ready_status_tb;
    logic core_clk = 1'h0, reset_n = 1'h0, valOn = 1'h0, coverOk = 1'h1;
    logic hopEmpty = 1'h1, sense = 1'h0, feed = 1'h0, atStk = 1'h0;
    logic strobe = 1'h0, inval = 1'h0, ask = 1'h0, take = 1'h0;
    logic loc = 1'h0, stkFull = 1'h0, bin = 1'h0;
    logic [6:0] btn = 7'h00;
    logic [5:0] colCh = 6'h00, charData;
    logic cycReq, retr, notReady, notReadyStatus, errorStatus, errorLamp;
    logic senseFaultLamp, cardJamLamp, badPunchLamp, jamStatus, flag;
    logic endOfDeckStatus, powerLamp, motorOn, controlActive, cardCycle;
    logic charValid;
    int num_errors = 0, samples_checked = 0;
    always #4 core_clk = ~core_clk;
    proc_ctrl_model PM (.core_clk, .reset_n, .askCycle(ask), .take,
        .cycleRequest(cycReq), .dataRetrieve(retr));
    card_reader_ready_status #(.POWER_DELAY(10)) DUT (.core_clk, .reset_n,
        .powerOnButton(btn[0]), .powerOffButton(btn[1]),
        .systemPowerOn(btn[2]), .startButton(btn[3]), .stopButton(btn[4]),
        .faultResetButton(btn[5]), .end_of_deck_button(btn[6]),
        .validityEnable(valOn), .localRun(loc), .coverClosed(coverOk),
        .hopperEmpty(hopEmpty), .stackerFull(stkFull), .senseFault(sense),
        .feedFault(feed), .cardAtStacker(atStk), .columnStrobe(strobe),
        .columnInvalid(inval), .binaryMode(bin), .columnChar(colCh),
        .cycleRequest(cycReq), .dataRetrieve(retr), .notReady,
        .notReadyStatus, .errorStatus, .errorLamp, .senseFaultLamp,
        .cardJamLamp, .badPunchLamp, .jamStatus, .endOfDeckStatus, .flag,
        .powerLamp, .motorOn, .controlActive, .cardCycle, .charData,
        .charValid);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time,
                seen, exp);
        end
    endtask : chk
    task automatic press(input int i);
        @(posedge core_clk);
        btn[i] <= 1'h1;
        tick(4);
        @(posedge core_clk);
        btn[i] <= 1'h0;
        tick(4);
    endtask : press
    task automatic cyc();
        @(posedge core_clk);
        ask <= 1'h1;
        @(posedge core_clk);
        ask <= 1'h0;
        tick(3);
    endtask : cyc
    task automatic ret();
        @(posedge core_clk);
        take <= 1'h1;
        @(posedge core_clk);
        take <= 1'h0;
        tick(2);
    endtask : ret
    task automatic stk();
        @(posedge core_clk);
        atStk <= 1'h1;
        @(posedge core_clk);
        atStk <= 1'h0;
        tick(2);
    endtask : stk
    task automatic column(input logic [5:0] c, input logic v);
        @(posedge core_clk);
        strobe <= 1'h1;
        colCh <= c;
        inval <= v;
        @(posedge core_clk);
        strobe <= 1'h0;
        inval <= 1'h0;
        tick(1);
    endtask : column
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power();
        chk(notReady, 6'h1);
        chk(flag, 6'h0);
        press(0);
        tick(12);
        chk(controlActive, 6'h1);
        chk(motorOn, 6'h1);
        chk(notReady, 6'h1);
    endtask : t_power
    task automatic t_deck();
        press(3);
        chk(notReady, 6'h1);
        press(6);
        chk(endOfDeckStatus, 6'h1);
        chk(flag, 6'h1);
        hopEmpty <= 1'h0;
        ret();
        tick(3);
        chk(endOfDeckStatus, 6'h0);
        chk(flag, 6'h0);
        press(3);
        chk(notReady, 6'h0);
    endtask : t_deck
    task automatic t_column();
        cyc();
        chk(cardCycle, 6'h1);
        column(6'h15, 1'h0);
        chk(charData, 6'h15);
        column(6'h2A, 1'h1);
        chk(charData, 6'h00);
        chk(badPunchLamp, 6'h0);
        ret();
        chk(charValid, 6'h0);
        chk(flag, 6'h0);
        sense <= 1'h1;
        tick(4);
        chk(senseFaultLamp, 6'h0);
        sense <= 1'h0;
        tick(4);
        stk();
        chk(cardCycle, 6'h0);
        ret();
    endtask : t_column
    task automatic t_badpunch();
        valOn <= 1'h1;
        cyc();
        bin <= 1'h1;
        column(6'h2A, 1'h1);
        chk(charData, 6'h2A);
        chk(badPunchLamp, 6'h0);
        bin <= 1'h0;
        column(6'h2A, 1'h1);
        chk(badPunchLamp, 6'h1);
        chk(errorStatus, 6'h1);
        chk(notReady, 6'h1);
        stk();
        ret();
        cyc();
        chk(cardCycle, 6'h0);
        press(5);
        chk(badPunchLamp, 6'h0);
        chk(errorStatus, 6'h0);
        press(3);
    endtask : t_badpunch
    task automatic t_sense();
        sense <= 1'h1;
        tick(5);
        chk(senseFaultLamp, 6'h1);
        chk(errorLamp, 6'h1);
        chk(notReady, 6'h1);
        sense <= 1'h0;
        press(5);
        chk(senseFaultLamp, 6'h0);
        press(3);
    endtask : t_sense
    task automatic t_jam();
        cyc();
        feed <= 1'h1;
        tick(5);
        chk(cardJamLamp, 6'h1);
        chk(motorOn, 6'h0);
        chk(cardCycle, 6'h0);
        chk(jamStatus, 6'h1);
        chk(flag, 6'h1);
        feed <= 1'h0;
        ret();
        press(5);
        press(3);
        chk(notReady, 6'h0);
    endtask : t_jam
    task automatic t_local();
        stkFull <= 1'h1;
        tick(3);
        chk(notReady, 6'h1);
        stkFull <= 1'h0;
        tick(3);
        chk(notReady, 6'h0);
        loc <= 1'h1;
        tick(4);
        chk(cardCycle, 6'h1);
        hopEmpty <= 1'h1;
        stk();
        chk(cardJamLamp, 6'h1);
        chk(cardCycle, 6'h0);
        loc <= 1'h0;
        hopEmpty <= 1'h0;
        ret();
        press(5);
    endtask : t_local
    task automatic t_stop();
        cyc();
        press(4);
        chk(notReady, 6'h1);
        chk(cardCycle, 6'h1);
        stk();
        coverOk <= 1'h0;
        tick(5);
        chk(notReadyStatus, 6'h1);
        chk(powerLamp, 6'h0);
    endtask : t_stop
    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'h1;
        tick(2);
        t_power();
        t_deck();
        t_column();
        t_badpunch();
        t_sense();
        t_jam();
        t_local();
        t_stop();
        complete_run();
    end
endmodule : card_reader_ready_status_tb
